// >>> rtl/sar_defs.svh
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH
`define SAR_RES_W 18
`define SAR_MSB 17
`define SAR_SER_BITS 5'd18
`define SAR_CONV_CYC 6'd40
`define SAR_INIT_CYC 6'd8
`define SAR_HALF_CYC 6'd20
`define SAR_MODE_P18 2'h0
`define SAR_MODE_P16 2'h1
`define SAR_MODE_P8 2'h2
`define SAR_MODE_SER 2'h3
`define SAR_SIGN_FLIP 18'h20000
`define SAR_DIV_BASE 4'h1
`define SAR_SYNC_IDLE 35'h100600000
`endif

// >>> rtl/sar_pkg.sv
`default_nettype none
package sar_pkg;
  typedef enum logic [1:0] {
    sar_idle = 2'b00,
    sar_conv = 2'b01,
    sar_shift = 2'b11,
    sar_init = 2'b10
  } sar_state_e;
  typedef logic [17:0] sar_word_t;
endpackage
`default_nettype wire

// >>> rtl/sar_if.sv
`default_nettype none
interface sar_if;
  logic [17:0] wdata;
  logic we;
  logic [17:0] rdata;
  modport ctl (output wdata, output we, input rdata);
  modport mem (input wdata, input we, output rdata);
endinterface
`default_nettype wire

// >>> rtl/sar_result_store.sv
`default_nettype none
module sar_result_store (
  input wire logic clk,
  input wire logic rst,
  sar_if.mem port
);
  logic [17:0] word_reg;
  logic [17:0] word_next;
  always_comb begin
    word_next = port.we ? port.wdata : word_reg;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      word_reg <= 18'h00000;
    end else begin
      word_reg <= word_next;
    end
  end
  assign port.rdata = word_reg;
endmodule // sar_result_store
`default_nettype wire

// >>> rtl/sar_readout.sv
// What this block does
// - coding pin picks twos complement or binary
// - bus outputs driven only while select, read low
// - reset rise aborts conversion, releases bus
// - reset fall clears bus, busy pulse init
// - mode field picks 18/16/8 bit or serial
// - host word select fetches words or bytes
// - selects held low: bus follows every result
// - serial 18 bits, msb first, per clock
// - serial bit changes on one clock edge, stable over the other
// - internal clock with sync, both invertible
// - read timing pin: after or during convert
// - during convert clock follows conversion steps
// - after convert busy holds until shifted out
// - divider pins slow after-convert serial clock
// - external clock rise gated by select and read, fall by select
// - continuous or gapped clock, either idle
// - host reads after busy falls
// - chain input taken on opposite edge
// - late during-convert read pulses overrun flag
// - convert start falling edge, no restart
`include "sar_defs.svh"
`default_nettype none
module sar_readout import sar_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // conversion control, pins
  input wire logic convert_start_n,
  input wire logic reset_pin,
  input wire logic power_down,
  input wire logic [17:0] sample_code,
  // interface configuration, pins
  input wire logic [1:0] mode,
  input wire logic coding_select,
  input wire logic clock_source_select,
  input wire logic read_timing_or_chain_in,
  input wire logic [1:0] serial_clock_divider,
  input wire logic sclk_invert,
  input wire logic sync_invert,
  // bus control, pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [1:0] word_select,
  input wire logic sclk_in,
  // outputs
  output logic [17:0] data_out,
  output logic [17:0] data_oe,
  output logic serial_data_out,
  output logic sclk_out,
  output logic sclk_oe,
  output logic sync_out,
  output logic busy,
  output logic read_overrun_flag
);
  // two-flop synchronisers for every pin input
  localparam int NS = 35;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  assign raw = {sclk_invert, sync_invert, convert_start_n, reset_pin, power_down, mode,
                coding_select, clock_source_select, read_timing_or_chain_in,
                serial_clock_divider, cs_n, rd_n, word_select, sclk_in, sample_code};
  always_ff @(posedge clk) begin
    if (rst) begin
      // idle levels, so no false start or reset edge follows rst
      s1_reg <= `SAR_SYNC_IDLE;
      s2_reg <= `SAR_SYNC_IDLE;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  logic cnv_n, rpin, pd_s, ob, ext, rdc, csn, rdn, sck, sinv, yinv;
  logic [1:0] md, dv, ws;
  sar_word_t code;
  // power down is synchronised but never touches a running conversion
  assign {sinv, yinv, cnv_n, rpin, pd_s, md, ob, ext, rdc, dv,
          csn, rdn, ws, sck, code} = s2_reg;

  function automatic logic [17:0] word_pick(input logic [1:0] m, input logic [1:0] a,
                                            input sar_word_t v);
    logic [17:0] r;
    r = v;
    case (m)
      `SAR_MODE_P16: r = (a == 2'h0) ? {2'h0, v[17:2]} : {16'h0000, v[1:0]};
      `SAR_MODE_P8: begin
        case (a)
          2'h0: r = {10'h000, v[17:10]};
          2'h1: r = {10'h000, v[9:2]};
          default: r = {16'h0000, v[1:0]};
        endcase
      end
      default: r = v;
    endcase
    return r;
  endfunction

  sar_if st_if ();
  sar_result_store u_store (
    .clk(clk),
    .rst(rst),
    .port(st_if)
  );

  sar_state_e state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [4:0] bit_reg, bit_next;
  logic [3:0] div_reg, div_next;
  logic [17:0] sh_reg, sh_next;
  logic [17:0] prev_reg, prev_next;
  logic cnv_q_reg, rpin_q_reg, sck_q_reg;
  logic ph_reg, ph_next, sck_reg, sck_next, sync_reg, sync_next;
  logic rdone_reg, rdone_next, err_reg, err_next, sdo_reg, sdo_next;
  logic busy_reg, busy_next, held_reg, held_next;
  logic sclko_reg, sclko_next, synco_reg, synco_next, soe_reg, soe_next;
  logic [17:0] dout_reg, dout_next, doe_reg, doe_next;
  logic start, sel, ser, int_rac, int_rdc, ext_rac, ext_rdc, sk_lead, sk_trail;
  logic [3:0] div_top;

  assign start = cnv_q_reg & ~cnv_n;
  assign sel = ~csn & ~rdn;
  assign ser = (md == `SAR_MODE_SER);
  assign int_rac = ser & ~ext & ~rdc;
  assign int_rdc = ser & ~ext & rdc;
  assign ext_rac = ser & ext & ~rdc;
  assign ext_rdc = ser & ext & rdc;
  // clock accepted only while selected, shifted on rise, sampled on fall
  assign sk_lead = ~csn & sel & sck & ~sck_q_reg;
  assign sk_trail = ~csn & ~sck & sck_q_reg;
  assign div_top = `SAR_DIV_BASE << dv;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    div_next = div_reg;
    sh_next = sh_reg;
    prev_next = prev_reg;
    ph_next = ph_reg;
    sck_next = sck_reg;
    sync_next = 1'b0;
    rdone_next = rdone_reg;
    err_next = 1'b0;
    busy_next = busy_reg;
    held_next = rpin;
    st_if.we = 1'b0;
    // offset binary flips the sign bit of the twos complement code
    st_if.wdata = ob ? (code ^ `SAR_SIGN_FLIP) : code;
    if (rpin) begin
      state_next = sar_idle;
      busy_next = 1'b0;
      sck_next = 1'b0;
    end else if (held_reg) begin
      state_next = sar_init;
      cnt_next = 6'h00;
      busy_next = 1'b1;
      st_if.we = 1'b1;
      st_if.wdata = 18'h00000;
    end else begin
      case (state_reg)
        sar_init: begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == `SAR_INIT_CYC) begin
            state_next = sar_idle;
            busy_next = 1'b0;
          end
        end
        sar_idle: begin
          if (start) begin
            state_next = sar_conv;
            cnt_next = 6'h00;
            busy_next = 1'b1;
            bit_next = 5'h00;
            rdone_next = 1'b0;
            sh_next = prev_reg;
            sck_next = 1'b0;
          end
          if (ext_rac && sk_lead && bit_reg < `SAR_SER_BITS) begin
            sh_next = {sh_reg[16:0], ph_reg};
            bit_next = bit_reg + 5'h01;
          end
          if (sk_trail) begin
            ph_next = rdc;
          end
        end
        sar_conv: begin
          cnt_next = cnt_reg + 6'h01;
          // previous result leaves at conversion pace, slower toward lsbs
          if (int_rdc && bit_reg < `SAR_SER_BITS &&
              cnt_reg >= {bit_reg, 1'b0} + {4'h0, bit_reg[4:3]}) begin
            sck_next = ~sck_reg;
            sync_next = 1'b1;
            if (sck_reg) begin
              sh_next = {sh_reg[16:0], 1'b0};
              bit_next = bit_reg + 5'h01;
            end
          end
          if (ext_rdc && sk_lead && bit_reg < `SAR_SER_BITS) begin
            sh_next = {sh_reg[16:0], 1'b0};
            bit_next = bit_reg + 5'h01;
          end
          if (cnt_reg == `SAR_CONV_CYC) begin
            st_if.we = 1'b1;
            prev_next = st_if.wdata;
            sh_next = st_if.wdata;
            sck_next = 1'b0;
            if (ext_rdc && bit_reg != `SAR_SER_BITS) begin
              err_next = 1'b1;
            end
            bit_next = 5'h00;
            div_next = 4'h0;
            if (int_rac) begin
              state_next = sar_shift;
            end else begin
              state_next = sar_idle;
              busy_next = 1'b0;
            end
          end
        end
        sar_shift: begin
          div_next = div_reg + 4'h1;
          sync_next = 1'b1;
          if (div_reg + 4'h1 >= div_top) begin
            div_next = 4'h0;
            sck_next = ~sck_reg;
            if (sck_reg) begin
              // data moves only on the falling edge, stable across the rise
              sh_next = {sh_reg[16:0], 1'b0};
              bit_next = bit_reg + 5'h01;
              if (bit_reg == `SAR_SER_BITS - 5'h01) begin
                state_next = sar_idle;
                busy_next = 1'b0;
                sync_next = 1'b0;
              end
            end
          end
        end
        default: state_next = sar_idle;
      endcase
    end
    sdo_next = sh_next[`SAR_MSB];
    sclko_next = sck_next ^ sinv;
    synco_next = sync_next ^ yinv;
    soe_next = int_rac | int_rdc;
  end

  always_comb begin
    // parallel modes follow every new result while selected
    dout_next = word_pick(md, ws, st_if.rdata);
    doe_next = (sel && !rpin && !ser) ? 18'h3ffff : 18'h00000;
    if (ser) begin
      dout_next = 18'h00000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= sar_idle;
      cnt_reg <= 6'h00;
      bit_reg <= 5'h00;
      div_reg <= 4'h0;
      sh_reg <= 18'h00000;
      prev_reg <= 18'h00000;
      ph_reg <= 1'b0;
      sck_reg <= 1'b0;
      sync_reg <= 1'b0;
      rdone_reg <= 1'b0;
      err_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sclko_reg <= 1'b0;
      synco_reg <= 1'b0;
      soe_reg <= 1'b0;
      busy_reg <= 1'b0;
      held_reg <= 1'b0;
      dout_reg <= 18'h00000;
      doe_reg <= 18'h00000;
      cnv_q_reg <= 1'b1;
      rpin_q_reg <= 1'b0;
      sck_q_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      div_reg <= div_next;
      sh_reg <= sh_next;
      prev_reg <= prev_next;
      ph_reg <= ph_next;
      sck_reg <= sck_next;
      sync_reg <= sync_next;
      rdone_reg <= rdone_next;
      err_reg <= err_next;
      sdo_reg <= sdo_next;
      sclko_reg <= sclko_next;
      synco_reg <= synco_next;
      soe_reg <= soe_next;
      busy_reg <= busy_next;
      held_reg <= held_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      cnv_q_reg <= cnv_n;
      rpin_q_reg <= rpin;
      sck_q_reg <= sck;
    end
  end

  assign data_out = dout_reg;
  assign data_oe = doe_reg;
  assign serial_data_out = sdo_reg;
  assign sclk_out = sclko_reg;
  assign sclk_oe = soe_reg;
  assign sync_out = synco_reg;
  assign busy = busy_reg;
  assign read_overrun_flag = err_reg;
endmodule // sar_readout
`default_nettype wire

// >>> bench/sar_readout_props.sv
`default_nettype none
module sar_readout_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic convert_start_n,
  input wire logic reset_pin,
  input wire logic [1:0] mode,
  input wire logic clock_source_select,
  input wire logic read_timing_or_chain_in,
  input wire logic cs_n,
  input wire logic rd_n,
  // outputs
  input wire logic [17:0] data_oe,
  input wire logic sclk_oe,
  input wire logic busy,
  input wire logic read_overrun_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // four cycles cover the input synchronisers
  a_bus_gate: assert property ((cs_n || rd_n)[*4] |-> data_oe == 18'h0)
    else $error("bus driven while deselected");
  a_bus_drive: assert property ((!cs_n && !rd_n && mode != 2'h3 && !reset_pin)[*4]
    |-> data_oe == 18'h3ffff)
    else $error("bus not driven while selected");
  a_reset_release: assert property (reset_pin[*4] |-> data_oe == 18'h0 && !busy)
    else $error("reset pin did not abort and release");
  a_busy_min: assert property (disable iff (rst || reset_pin)
    $rose(busy) |-> busy[*6])
    else $error("busy pulse too short");
  a_busy_bound: assert property (disable iff (rst || reset_pin)
    $rose(busy) && clock_source_select |-> ##[6:48] !busy)
    else $error("busy did not fall in time");
  a_start_busy: assert property ($fell(convert_start_n) && !busy && !reset_pin
    |-> ##[1:6] busy)
    else $error("start edge did not raise busy");
  a_overrun_pulse: assert property (read_overrun_flag |=> !read_overrun_flag)
    else $error("overrun flag longer than one cycle");
  a_overrun_mode: assert property (read_overrun_flag |-> clock_source_select
    && read_timing_or_chain_in && mode == 2'h3)
    else $error("overrun flag outside its mode");
  a_host_clock: assert property (clock_source_select[*4] |-> !sclk_oe)
    else $error("serial clock driven with host clock");
endmodule // sar_readout_props
bind sar_readout sar_readout_props sar_readout_props_i (.clk, .rst, .convert_start_n,
  .reset_pin, .mode, .clock_source_select, .read_timing_or_chain_in, .cs_n, .rd_n,
  .data_oe, .sclk_oe, .busy, .read_overrun_flag);
`default_nettype wire

// >>> bench/sar_host_model.sv
`default_nettype none
module sar_host_model (
  // from bench and device
  input wire logic clk,
  input wire logic go,
  input wire logic sdo,
  // to bench and device
  output logic sclk,
  output logic [17:0] word,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    done = 1'b0;
    word = 18'h0;
    forever begin
      @(posedge go);
      done = 1'b0;
      // gapped clock idles low, started only after busy falls
      for (int i = 0; i < 18; i++) begin
        repeat (6) @(negedge clk);
        // the device moves to the next bit a few cycles after this rise
        word = {word[16:0], sdo};
        sclk = 1'b1;
        repeat (6) @(negedge clk);
        sclk = 1'b0;
      end
      done = 1'b1;
    end
  end
endmodule // sar_host_model
`default_nettype wire

// >>> bench/sar_adc_result_readout_port_tb.sv
`default_nettype none
module sar_adc_result_readout_port_tb import sar_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [1:0] m; logic cod; logic [1:0] ws; sar_word_t exp;} sar_row_s;
  logic clk, rst, convert_start_n, reset_pin, power_down, coding_select, go, done;
  logic clock_source_select, read_timing_or_chain_in, cs_n, rd_n, sclk_in;
  logic sclk_invert, sync_invert;
  logic [1:0] mode, word_select, serial_clock_divider;
  logic [17:0] data_out, data_oe, host_word;
  sar_word_t sample_code;
  logic serial_data_out, sclk_out, sclk_oe, sync_out, busy, read_overrun_flag;
  int fails = 0;
  int tests_run = 0;
  int ovr = 0;
  sar_row_s rows [7] = '{'{2'h0, 1'b0, 2'h0, 18'h2b3c5}, '{2'h0, 1'b1, 2'h0, 18'h0b3c5},
    '{2'h1, 1'b0, 2'h0, 18'h0acf1}, '{2'h1, 1'b0, 2'h1, 18'h00001},
    '{2'h2, 1'b0, 2'h0, 18'h000ac}, '{2'h2, 1'b0, 2'h1, 18'h000f1},
    '{2'h2, 1'b0, 2'h2, 18'h00001}};
  sar_readout sar_readout_i (.clk, .rst, .convert_start_n, .reset_pin, .power_down,
    .sample_code, .mode, .coding_select, .clock_source_select, .read_timing_or_chain_in,
    .serial_clock_divider, .sclk_invert, .sync_invert, .cs_n, .rd_n,
    .word_select, .sclk_in, .data_out, .data_oe, .serial_data_out, .sclk_out, .sclk_oe,
    .sync_out, .busy, .read_overrun_flag);
  sar_host_model sar_host_model_i (.clk, .go, .sdo(serial_data_out), .sclk(sclk_in),
    .word(host_word), .done);
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // pin held low long enough to pass the synchronisers
  task automatic start;
    @(negedge clk);
    convert_start_n = 1'b0;
    repeat (4) @(negedge clk);
    convert_start_n = 1'b1;
  endtask
  task automatic wait_busy(output int w);
    int n;
    n = 0;
    w = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    while (busy === 1'b1 && w < 400) begin
      @(negedge clk);
      w++;
    end
  endtask
  task automatic select(input logic s);
    cs_n = !s;
    rd_n = !s;
    repeat (5) @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (read_overrun_flag === 1'b1) begin
      ovr++;
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    int w;
    rst = 1'b1;
    {convert_start_n, cs_n, rd_n, clock_source_select} = 4'hf;
    {reset_pin, power_down, coding_select, go, read_timing_or_chain_in} = 5'h0;
    {sclk_invert, sync_invert} = 2'h0;
    mode = 2'h0;
    {word_select, serial_clock_divider} = 4'h0;
    sample_code = 18'h2b3c5;
    repeat (20) @(negedge clk);
    check(data_oe, 18'h0);
    check(18'(busy), 18'h0);
    rst = 1'b0;
    foreach (rows[i]) begin
      mode = rows[i].m;
      coding_select = rows[i].cod;
      word_select = rows[i].ws;
      start();
      wait_busy(w);
      check(18'(w >= 36 && w <= 46), 18'h1);
      select(1'b1);
      check(data_out, rows[i].exp);
      check(data_oe, 18'h3ffff);
      select(1'b0);
    end
    {mode, coding_select, word_select} = 5'h0;
    cs_n = 1'b0;
    repeat (5) @(negedge clk);
    check(data_oe, 18'h0);
    // second start and power down while converting change nothing
    sample_code = 18'h15555;
    start();
    power_down = 1'b1;
    start();
    wait_busy(w);
    check(18'(w >= 26 && w <= 38), 18'h1);
    power_down = 1'b0;
    select(1'b1);
    check(data_out, 18'h15555);
    start();
    repeat (6) @(negedge clk);
    reset_pin = 1'b1;
    repeat (6) @(negedge clk);
    check(data_oe, 18'h0);
    check(18'(busy), 18'h0);
    reset_pin = 1'b0;
    wait_busy(w);
    check(18'(w >= 4 && w <= 12), 18'h1);
    repeat (3) @(negedge clk);
    check(data_out, 18'h0);
    select(1'b0);
    mode = 2'h3;
    sample_code = 18'h2b3c5;
    start();
    wait_busy(w);
    select(1'b1);
    go = 1'b1;
    w = 0;
    while (done !== 1'b1 && w < 400) begin
      @(negedge clk);
      w++;
    end
    go = 1'b0;
    check(host_word, 18'h2b3c5);
    check(data_oe, 18'h0);
    read_timing_or_chain_in = 1'b1;
    ovr = 0;
    start();
    wait_busy(w);
    repeat (4) @(negedge clk);
    check(18'(ovr), 18'h1);
    {clock_source_select, read_timing_or_chain_in} = 2'h0;
    // divide by two and both polarities inverted
    {serial_clock_divider, sclk_invert, sync_invert} = 4'h7;
    start();
    wait_busy(w);
    check(18'(w >= 106 && w <= 118), 18'h1);
    check({16'h0000, sclk_oe, sclk_out}, 18'h3);
    check(18'(sync_out), 18'h1);
    read_timing_or_chain_in = 1'b1;
    start();
    wait_busy(w);
    check(18'(w >= 36 && w <= 46), 18'h1);
    check(18'(ovr), 18'h1);
    final_report();
  end
endmodule // sar_adc_result_readout_port_tb
`default_nettype wire
